// ### shared/ceq_pkg.sv
package ceq_pkg;
    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] CEQ_CACHE_MASK_OFS = 8'h00;
    localparam logic [7:0] CEQ_BUS_MASK_OFS = 8'h04;
    localparam logic [7:0] CEQ_CTRL_OFS = 8'h08;
    localparam logic [7:0] CEQ_CACHE_CNT_OFS = 8'h0C;
    localparam logic [7:0] CEQ_BUS_CNT_OFS = 8'h10;
    localparam logic [7:0] CEQ_STATUS_OFS = 8'h14;

    // ************************************************************
    // Cache-reference mask bit positions
    // ************************************************************
    localparam int CEQ_L2_HIT_S_BIT = 0;
    localparam int CEQ_L3_HIT_S_BIT = 3;
    localparam int CEQ_L2_MISS_BIT = 8;
    localparam int CEQ_L3_MISS_BIT = 9;
    localparam int CEQ_L2_WB_MISS_BIT = 10;

    // ************************************************************
    // Bus allocation mask bit positions
    // ************************************************************
    localparam int CEQ_REQ_TYPE_LSB = 0;
    localparam int CEQ_REQ_TYPE_W = 5;
    localparam int CEQ_ALL_READ_BIT = 5;
    localparam int CEQ_ALL_WRITE_BIT = 6;
    localparam int CEQ_MEM_TYPE_LSB = 7;
    localparam int CEQ_OWN_AGENT_BIT = 13;
    localparam int CEQ_OTHER_AGENT_BIT = 14;
    localparam int CEQ_PREFETCH_BIT = 15;

    // ************************************************************
    // Reset values and widths
    // ************************************************************
    localparam int CEQ_MASK_W = 16;
    localparam int CEQ_CNT_W = 32;
    localparam logic [15:0] CEQ_MASK_RST = 16'h0000;
    localparam logic [1:0] CEQ_CTRL_RST = 2'h0;

    // Coherence state of a hit
    typedef enum logic [1:0] {
        CEQ_ST_SHARED = 2'h0,
        CEQ_ST_EXCL = 2'h1,
        CEQ_ST_MOD = 2'h2
    } ceq_state_t;

    // Bus slave phase
    typedef enum logic [1:0] {
        CEQ_BUS_IDLE = 2'b00,
        CEQ_BUS_DATA = 2'b01
    } ceq_bus_phase_t;
endpackage : ceq_pkg

// ### shared/ceq_event_if.sv
interface ceq_event_if;
    logic cache_hit;
    logic cache_cnt;
    logic bus_hit;
    logic bus_cnt;
    modport qual (output cache_hit, output bus_hit);
    modport top (input cache_hit, input bus_hit);
    modport cnt_cache (input cache_hit);
    modport cnt_bus (input bus_hit);
endinterface : ceq_event_if

// ### rtl/ceq_cache_qual.sv
module ceq_cache_qual
    import ceq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Programmed mask
    input wire logic [15:0] mask,
    // Cache lookup report
    input wire logic ref_valid,
    input wire logic ref_is_load,
    input wire logic ref_is_rfo,
    input wire logic ref_is_wb,
    input wire logic ref_l3,
    input wire logic ref_hit,
    input wire ceq_state_t ref_state,
    // Result
    output logic hit
);
    logic rd;
    logic [2:0] st_sel;
    logic [2:0] l2_sel;
    logic [2:0] l3_sel;

    assign rd = ref_is_load | ref_is_rfo;
    assign st_sel = {ref_state == CEQ_ST_MOD, ref_state == CEQ_ST_EXCL, ref_state == CEQ_ST_SHARED};
    assign l2_sel = mask[CEQ_L2_HIT_S_BIT +: 3];
    assign l3_sel = mask[CEQ_L3_HIT_S_BIT +: 3];

    always_ff @(posedge clk) begin
        if (rst) begin
            hit <= 1'b0;
        end else begin
            hit <= ref_valid & (
                (rd & ~ref_l3 & ref_hit & |(l2_sel & st_sel)) |
                (rd & ref_l3 & ref_hit & |(l3_sel & st_sel)) |
                (rd & ~ref_l3 & ~ref_hit & mask[CEQ_L2_MISS_BIT]) |
                (rd & ref_l3 & ~ref_hit & mask[CEQ_L3_MISS_BIT]) |
                (ref_is_wb & ~ref_l3 & ~ref_hit & mask[CEQ_L2_WB_MISS_BIT]));
        end
    end
endmodule : ceq_cache_qual

// ### rtl/ceq_bus_qual.sv
module ceq_bus_qual
    import ceq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Programmed mask
    input wire logic [15:0] mask,
    // Queue allocation report
    input wire logic alloc_valid,
    input wire logic [4:0] alloc_req_type,
    input wire logic alloc_is_read,
    input wire logic alloc_is_write,
    input wire logic alloc_is_prefetch,
    input wire logic [1:0] alloc_mem_type,
    input wire logic alloc_own,
    // Result
    output logic hit
);
    logic type_m;
    logic rd_m;
    logic wr_m;
    logic mem_m;
    logic src_m;
    logic pf_ok;

    // Request-type field, OR of set bits
    assign type_m = |(mask[CEQ_REQ_TYPE_LSB +: CEQ_REQ_TYPE_W] & alloc_req_type);
    assign pf_ok = ~alloc_is_prefetch | mask[CEQ_PREFETCH_BIT];
    assign rd_m = mask[CEQ_ALL_READ_BIT] & alloc_is_read & pf_ok;
    assign wr_m = mask[CEQ_ALL_WRITE_BIT] & alloc_is_write;
    assign mem_m = |(mask[CEQ_MEM_TYPE_LSB +: 2] & alloc_mem_type);
    assign src_m = (mask[CEQ_OWN_AGENT_BIT] & alloc_own) | (mask[CEQ_OTHER_AGENT_BIT] & ~alloc_own);

    always_ff @(posedge clk) begin
        if (rst) begin
            hit <= 1'b0;
        end else begin
            // One per allocation; sector or chunk alike; retries recount
            hit <= alloc_valid & (type_m | rd_m | wr_m | mem_m) & src_m;
        end
    end
endmodule : ceq_bus_qual

// ### rtl/ceq_top.sv
// Operation
// - Mask bits 0-2 count L2 read hits in shared, exclusive, modified state.
// - Mask bits 3-5 count L3 read hits in shared, exclusive, modified state.
// - Mask bit 8 counts L2 read misses and bit 9 counts L3 read misses.
// - Mask bit 10 counts writeback lookups missing the L2.
// - Loads and ownership reads both count as reads.
// - Each matching queue allocation counts once.
// - A queue entry counts the same whether a 64-byte sector or an 8-byte chunk.
// - Each retry of a request counts again.
// - Bus mask bits 0-4 form one request-type field matched by OR.
// - Bus mask bits 7 and 8 select the target memory type.
// - Bus mask bits 13 and 14 select the source agent.
// - Bus mask bit 15 affects only read qualification.
// - Event fires on (type or bit 5 or bit 6 or memory) and source.
//
// Our own choices: the register addresses and register access over AHB-Lite.
module ceq_top
    import ceq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Cache lookup report
    input wire logic ref_valid,
    input wire logic ref_is_load,
    input wire logic ref_is_rfo,
    input wire logic ref_is_wb,
    input wire logic ref_l3,
    input wire logic ref_hit,
    input wire logic [1:0] ref_state,
    // Queue allocation report
    input wire logic alloc_valid,
    input wire logic [4:0] alloc_req_type,
    input wire logic alloc_is_read,
    input wire logic alloc_is_write,
    input wire logic alloc_is_prefetch,
    input wire logic [1:0] alloc_mem_type,
    input wire logic alloc_own,
    // Event pulses
    output logic cache_event,
    output logic bus_event
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0] cache_mask_reg;
    logic [15:0] bus_mask_reg;
    logic [1:0] ctrl_reg;
    logic [31:0] cache_cnt_reg;
    logic [31:0] bus_cnt_reg;
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic cache_hit;
    logic bus_hit;
    logic cache_wr;
    logic bus_wr;

    ceq_event_if ev ();

    ceq_cache_qual u_cache (
        .clk(clk),
        .rst(rst),
        .mask(cache_mask_reg),
        .ref_valid(ref_valid),
        .ref_is_load(ref_is_load),
        .ref_is_rfo(ref_is_rfo),
        .ref_is_wb(ref_is_wb),
        .ref_l3(ref_l3),
        .ref_hit(ref_hit),
        .ref_state(ceq_state_t'(ref_state)),
        .hit(ev.cache_hit)
    );

    ceq_bus_qual u_bus (
        .clk(clk),
        .rst(rst),
        .mask(bus_mask_reg),
        .alloc_valid(alloc_valid),
        .alloc_req_type(alloc_req_type),
        .alloc_is_read(alloc_is_read),
        .alloc_is_write(alloc_is_write),
        .alloc_is_prefetch(alloc_is_prefetch),
        .alloc_mem_type(alloc_mem_type),
        .alloc_own(alloc_own),
        .hit(ev.bus_hit)
    );

    // Counting only while enabled in ctrl
    assign cache_hit = ev.cache_hit & ctrl_reg[0];
    assign bus_hit = ev.bus_hit & ctrl_reg[1];
    assign ev.cache_cnt = cache_hit;
    assign ev.bus_cnt = bus_hit;

    // ************************************************************
    // AHB-Lite slave, zero wait states
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel & htrans[1] & hwrite;
            addr_reg <= haddr;
        end
    end

    assign cache_wr = wr_pend_reg & (addr_reg == CEQ_CACHE_CNT_OFS);
    assign bus_wr = wr_pend_reg & (addr_reg == CEQ_BUS_CNT_OFS);

    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cache_mask_reg <= CEQ_MASK_RST;
            bus_mask_reg <= CEQ_MASK_RST;
            ctrl_reg <= CEQ_CTRL_RST;
        end else if (wr_pend_reg) begin
            if (addr_reg == CEQ_CACHE_MASK_OFS) begin
                cache_mask_reg <= hwdata[15:0];
            end else if (addr_reg == CEQ_BUS_MASK_OFS) begin
                bus_mask_reg <= hwdata[15:0];
            end else if (addr_reg == CEQ_CTRL_OFS) begin
                ctrl_reg <= hwdata[1:0];
            end
        end
    end

    // Read data registered in the address phase
    always_ff @(posedge clk) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready & hsel & htrans[1] & ~hwrite) begin
            if (haddr == CEQ_CACHE_MASK_OFS) begin
                hrdata <= {16'h0000, cache_mask_reg};
            end else if (haddr == CEQ_BUS_MASK_OFS) begin
                hrdata <= {16'h0000, bus_mask_reg};
            end else if (haddr == CEQ_CTRL_OFS) begin
                hrdata <= {30'h0000_0000, ctrl_reg};
            end else if (haddr == CEQ_CACHE_CNT_OFS) begin
                hrdata <= cache_cnt_reg;
            end else if (haddr == CEQ_BUS_CNT_OFS) begin
                hrdata <= bus_cnt_reg;
            end else if (haddr == CEQ_STATUS_OFS) begin
                hrdata <= {30'h0000_0000, ev.bus_hit, ev.cache_hit};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // Counters
    // ************************************************************
    // One per event; a software write loads its value plus any event of that cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cache_cnt_reg <= 32'h0000_0000;
        end else if (cache_wr) begin
            cache_cnt_reg <= hwdata + {31'h0000_0000, ev.cache_cnt};
        end else if (ev.cache_cnt) begin
            cache_cnt_reg <= cache_cnt_reg + 32'h0000_0001;
        end
    end

    // Bus counter, retries counted each time
    always_ff @(posedge clk) begin
        if (rst) begin
            bus_cnt_reg <= 32'h0000_0000;
        end else if (bus_wr) begin
            bus_cnt_reg <= hwdata + {31'h0000_0000, ev.bus_cnt};
        end else if (ev.bus_cnt) begin
            bus_cnt_reg <= bus_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cache_event <= 1'b0;
            bus_event <= 1'b0;
        end else begin
            cache_event <= cache_hit;
            bus_event <= bus_hit;
        end
    end
endmodule : ceq_top

// ### testbench/ceq_properties.sv
module ceq_checker
    import ceq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Cache lookup report
    input wire logic ref_valid,
    input wire logic ref_is_load,
    input wire logic ref_is_rfo,
    input wire logic ref_is_wb,
    input wire logic ref_l3,
    input wire logic ref_hit,
    input wire logic [1:0] ref_state,
    // Queue allocation report
    input wire logic alloc_valid,
    input wire logic [4:0] alloc_req_type,
    input wire logic alloc_is_read,
    input wire logic alloc_is_write,
    input wire logic alloc_is_prefetch,
    input wire logic [1:0] alloc_mem_type,
    input wire logic alloc_own,
    // Event pulses
    input wire logic cache_event,
    input wire logic bus_event
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wp_reg;
    logic [7:0] wa_reg;
    logic [15:0] cm_reg;
    logic [15:0] bm_reg;
    logic [1:0] ce_reg;
    logic rd;
    logic cq;
    logic bq;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_reg <= 1'b0;
        end else if (hready) begin
            wp_reg <= hsel && htrans[1] && hwrite;
        end
    end
    always_ff @(posedge clk) begin
        if (hready) begin
            wa_reg <= haddr;
        end
    end
    // Shadow masks follow the write at the same edge as the block
    always_ff @(posedge clk) begin
        if (rst) begin
            cm_reg <= 16'h0000;
            bm_reg <= 16'h0000;
            ce_reg <= 2'h0;
        end else if (wp_reg && hready) begin
            if (wa_reg == CEQ_CACHE_MASK_OFS) cm_reg <= hwdata[15:0];
            if (wa_reg == CEQ_BUS_MASK_OFS) bm_reg <= hwdata[15:0];
            if (wa_reg == CEQ_CTRL_OFS) ce_reg <= hwdata[1:0];
        end
    end
    always_comb begin
        rd = ref_is_load || ref_is_rfo;
        cq = ref_valid && (rd && ref_hit && ref_state != 2'h3 && cm_reg[(ref_l3 ? 3 : 0) + ref_state]
            || rd && !ref_hit && cm_reg[ref_l3 ? 9 : 8] || ref_is_wb && !ref_hit && !ref_l3 && cm_reg[10]);
        bq = alloc_valid && ((alloc_req_type & bm_reg[4:0]) != 5'h00
            || bm_reg[5] && alloc_is_read && (!alloc_is_prefetch || bm_reg[15])
            || bm_reg[6] && alloc_is_write || (alloc_mem_type & bm_reg[8:7]) != 2'h0)
            && (bm_reg[13] && alloc_own || bm_reg[14] && !alloc_own);
    end
    chk_cache_fire: assert property (
        cq && ce_reg[0] ##1 ce_reg[0] |-> ##1 cache_event) else $error("cache event missing");
    chk_cache_block: assert property (
        !cq |-> ##2 !cache_event) else $error("cache event without cause");
    chk_bus_fire: assert property (
        bq && ce_reg[1] ##1 ce_reg[1] |-> ##1 bus_event) else $error("bus event missing");
    chk_bus_block: assert property (
        !bq |-> ##2 !bus_event) else $error("bus event without cause");
    chk_resp_okay: assert property (
        hresp == 1'b0) else $error("response not okay");
    chk_ready_high: assert property (
        hreadyout) else $error("wait state inserted");
    chk_reset_quiet: assert property (
        $fell(rst) |-> !cache_event && !bus_event && hrdata == 32'h0) else $error("outputs not cleared");
    chk_rd_unmapped: assert property (
        hready && hsel && htrans[1] && !hwrite && haddr == 8'h18 |=> hrdata == 32'h0) else $error("unmapped read");
endmodule : ceq_checker

bind ceq_top ceq_checker u_ceq_checker (.*);

// ### testbench/ceq_far_model.sv
module ceq_far_model (
    // Clock
    input wire logic clk,
    // Cache lookup report
    output logic ref_valid,
    output logic ref_is_load,
    output logic ref_is_rfo,
    output logic ref_is_wb,
    output logic ref_l3,
    output logic ref_hit,
    output logic [1:0] ref_state,
    // Queue allocation report
    output logic alloc_valid,
    output logic [4:0] alloc_req_type,
    output logic alloc_is_read,
    output logic alloc_is_write,
    output logic alloc_is_prefetch,
    output logic [1:0] alloc_mem_type,
    output logic alloc_own
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ref_valid = 1'b0;
        alloc_valid = 1'b0;
        {ref_l3, ref_hit, ref_state, ref_is_load, ref_is_rfo, ref_is_wb} = 7'h00;
        {alloc_req_type, alloc_is_read, alloc_is_write, alloc_is_prefetch, alloc_mem_type, alloc_own} = 11'h000;
    end
    // Released fields show junk, never the last report
    task look(input logic [6:0] k);
        ref_valid <= 1'b1;
        {ref_l3, ref_hit, ref_state, ref_is_load, ref_is_rfo, ref_is_wb} <= k;
        @(posedge clk);
        ref_valid <= 1'b0;
        {ref_l3, ref_hit, ref_state, ref_is_load, ref_is_rfo, ref_is_wb} <= ~k;
    endtask : look
    // Each retry is a fresh allocation cycle
    task alloc(input logic [10:0] k, input int n);
        alloc_valid <= 1'b1;
        {alloc_req_type, alloc_is_read, alloc_is_write, alloc_is_prefetch, alloc_mem_type, alloc_own} <= k;
        repeat (n) @(posedge clk);
        alloc_valid <= 1'b0;
        {alloc_req_type, alloc_is_read, alloc_is_write, alloc_is_prefetch, alloc_mem_type, alloc_own} <= ~k;
    endtask : alloc
endmodule : ceq_far_model

// ### testbench/ceq_tb_top.sv
module ceq_tb_top
    import ceq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic hready;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, cache_event, bus_event;
    logic ref_valid, ref_is_load, ref_is_rfo, ref_is_wb, ref_l3, ref_hit;
    logic [1:0] ref_state;
    logic alloc_valid, alloc_is_read, alloc_is_write, alloc_is_prefetch, alloc_own;
    logic [4:0] alloc_req_type;
    logic [1:0] alloc_mem_type;
    logic [31:0] v;
    int n_fail = 0;
    int n_tests = 0;
    int i;
    // Index, l3, hit, state, load, rfo, writeback
    logic [10:0] ct [9] = '{11'h024, 11'h0AA, 11'h134, 11'h1E2, 11'h26C, 11'h2F2, 11'h402, 11'h4C4, 11'h501};
    assign hready = hreadyout;
    always #2.5 clk = ~clk;
    ceq_top u_ceq_top (.*);
    ceq_far_model u_ceq_far_model (.*);
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task cmp_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t event %b expected %b", $time, got, exp);
        end
    endtask : cmp_bit
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : xfer
    task cev(input logic [10:0] c, input logic pos);
        logic [15:0] m;
        m = 16'h0001 << c[10:7];
        xfer(CEQ_CACHE_MASK_OFS, 1'b1, {16'h0000, pos ? m : 16'h073F & ~m}, v);
        u_ceq_far_model.look(c[6:0]);
        @(posedge clk);
        @(posedge clk);
        cmp_bit(cache_event, pos);
    endtask : cev
    task bcs(input logic [15:0] m, input logic [10:0] k, input logic e, input int n);
        xfer(CEQ_BUS_MASK_OFS, 1'b1, {16'h0000, m}, v);
        u_ceq_far_model.alloc(k, n);
        @(posedge clk);
        cmp_bit(bus_event, e && n == 2);
        @(posedge clk);
        cmp_bit(bus_event, e);
    endtask : bcs
    task tally_and_finish;
        $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    // Run needs a few hundred cycles; allow over twenty times that
    initial begin
        #25000;
        n_fail++;
        $display("BAD %0t timeout", $time);
        tally_and_finish;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 7; i++) begin
            xfer(8'(i * 4), 1'b0, 32'h0, v);
            cmp_word(v, 32'h0);
        end
        xfer(CEQ_CTRL_OFS, 1'b1, 32'hFFFF_FFFF, v);
        xfer(CEQ_CTRL_OFS, 1'b0, 32'h0, v);
        cmp_word(v, 32'h3);
        for (i = 0; i < 9; i++) begin
            cev(ct[i], 1'b1);
            cev(ct[i], 1'b0);
        end
        xfer(CEQ_CACHE_CNT_OFS, 1'b0, 32'h0, v);
        cmp_word(v, 32'h9);
        bcs(16'h2001, 11'h041, 1'b1, 1);
        bcs(16'h2006, 11'h101, 1'b1, 1);
        bcs(16'h2002, 11'h041, 1'b0, 1);
        bcs(16'h2020, 11'h021, 1'b1, 1);
        bcs(16'h2020, 11'h029, 1'b0, 1);
        bcs(16'hA020, 11'h029, 1'b1, 1);
        bcs(16'h2040, 11'h019, 1'b1, 1);
        bcs(16'h2080, 11'h003, 1'b1, 1);
        bcs(16'h2100, 11'h003, 1'b0, 1);
        bcs(16'h2100, 11'h005, 1'b1, 1);
        bcs(16'h4001, 11'h041, 1'b0, 1);
        bcs(16'h4001, 11'h040, 1'b1, 1);
        bcs(16'h0001, 11'h040, 1'b0, 1);
        bcs(16'h6001, 11'h041, 1'b1, 2);
        xfer(CEQ_BUS_CNT_OFS, 1'b0, 32'h0, v);
        cmp_word(v, 32'hA);
        xfer(CEQ_BUS_CNT_OFS, 1'b1, 32'h5, v);
        xfer(CEQ_BUS_CNT_OFS, 1'b0, 32'h0, v);
        cmp_word(v, 32'h5);
        // Counter write lands at the edge of an increment
        fork
            u_ceq_far_model.alloc(11'h041, 1);
            xfer(CEQ_BUS_CNT_OFS, 1'b1, 32'h9, v);
        join
        xfer(CEQ_BUS_CNT_OFS, 1'b0, 32'h0, v);
        cmp_word(v, 32'hA);
        // Second reset in mid-run
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        xfer(CEQ_BUS_CNT_OFS, 1'b0, 32'h0, v);
        cmp_word(v, 32'h0);
        xfer(CEQ_BUS_MASK_OFS, 1'b0, 32'h0, v);
        cmp_word(v, 32'h0);
        tally_and_finish;
    end
endmodule : ceq_tb_top
